//--- rtl/wdt_pkg.sv
// package: register map, fields, timing and types of the watchdog unit
package wdt_pkg;
  // special function register addresses
  localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'h8E;
  localparam logic [7:0] TIMED_ACCESS_KEY_ADDR = 8'hC7;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hD8;
  // reset values
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h03;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
  // clock_control fields
  localparam int WDT_INTERVAL_SEL_HI = 7;
  localparam int WDT_INTERVAL_SEL_LO = 6;
  localparam int CLK_MODE_HI = 2;
  localparam int CLK_MODE_LO = 0;
  // watchdog_control bit positions
  localparam int WDT_RESTART_BIT = 0;
  localparam int WDT_RESET_ENABLE_BIT = 1;
  localparam int WDT_RESET_FLAG_BIT = 2;
  localparam int WDT_IRQ_FLAG_BIT = 3;
  // unlock key bytes
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h55;
  // counter width in bits; timing, in clock periods
  localparam int WDT_CNT_WIDTH = 27;
  localparam int WDT_GRACE_CLOCKS = 512;
  localparam logic [8:0] WDT_GRACE_LAST = 9'(WDT_GRACE_CLOCKS - 1);
  // interval counts
  localparam logic [26:0] WDT_INTERVAL_00 = 27'h002_0000;
  localparam logic [26:0] WDT_INTERVAL_01 = 27'h010_0000;
  localparam logic [26:0] WDT_INTERVAL_10 = 27'h080_0000;
  localparam logic [26:0] WDT_INTERVAL_11 = 27'h400_0000;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdt_sfr_req_t;

  typedef enum logic [1:0] {
    WDT_LOCK_IDLE = 2'b00,
    WDT_LOCK_FIRST = 2'b01,
    WDT_LOCK_OPEN = 2'b10
  } wdt_lock_t;

  typedef enum logic {
    WDT_CNT_RUN = 1'b0,
    WDT_CNT_GRACE = 1'b1
  } wdt_cnt_state_t;
endpackage

//--- rtl/wdt_counter.sv
// interval and grace counter of the watchdog
module wdt_counter (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control
  input wire logic restart,
  input wire logic [26:0] limit,
  // events
  output logic expire_pulse,
  output logic grace_done_pulse
);
  wdt_pkg::wdt_cnt_state_t state_reg;
  wdt_pkg::wdt_cnt_state_t state_next;
  logic [26:0] cnt_reg;
  logic [26:0] cnt_next;
  logic [8:0] grace_reg;
  logic [8:0] grace_next;
  logic expire_next;
  logic done_next;
  wire logic [26:0] last_w = limit - 27'h000_0001;
  wire logic at_last_w = (cnt_reg == last_w);
  wire logic grace_end_w = (grace_reg == wdt_pkg::WDT_GRACE_LAST);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    grace_next = grace_reg;
    expire_next = 1'b0;
    done_next = 1'b0;
    if (restart) begin
      state_next = wdt_pkg::WDT_CNT_RUN; // [RULE10]
      cnt_next = '0; // [RULE10]
      grace_next = '0;
    end else begin
      case (state_reg)
        wdt_pkg::WDT_CNT_RUN: begin
          if (at_last_w) begin
            state_next = wdt_pkg::WDT_CNT_GRACE; // [RULE8]
            grace_next = '0;
            expire_next = 1'b1; // [RULE8]
          end else begin
            cnt_next = cnt_reg + 27'h000_0001; // [RULE6]
          end
        end
        default: begin
          if (grace_end_w) begin
            // keeps timing after the grace, so an unattended unit repeats
            state_next = wdt_pkg::WDT_CNT_RUN;
            cnt_next = '0;
            done_next = 1'b1; // [RULE8]
          end else begin
            grace_next = grace_reg + 9'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= wdt_pkg::WDT_CNT_RUN;
      cnt_reg <= '0;
      grace_reg <= '0;
      expire_pulse <= 1'b0;
      grace_done_pulse <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      grace_reg <= grace_next;
      expire_pulse <= expire_next;
      grace_done_pulse <= done_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_RESTART_CLEARS: assert property ( // [RULE10]
    restart |=> (cnt_reg == '0) && (state_reg == wdt_pkg::WDT_CNT_RUN))
    else $error("restart did not clear the count");
  AST_COUNT_EVERY_CLOCK: assert property ( // [RULE6]
    (state_reg == wdt_pkg::WDT_CNT_RUN) && !restart && !at_last_w
    |=> cnt_reg == $past(cnt_reg) + 27'h000_0001)
    else $error("count skipped a clock");
  AST_GRACE_END: assert property ( // [RULE8]
    (state_reg == wdt_pkg::WDT_CNT_GRACE) && grace_end_w && !restart
    |=> grace_done_pulse && (cnt_reg == '0))
    else $error("grace end not flagged at count 511");
  AST_EXPIRE_AT_LIMIT: assert property ( // [RULE8]
    (state_reg == wdt_pkg::WDT_CNT_RUN) && at_last_w && !restart
    |=> expire_pulse && (grace_reg == '0) ##1 !expire_pulse)
    else $error("interval expiry not flagged once");
endmodule // wdt_counter

//--- rtl/wdt_top.sv
// watchdog timeout and reset unit with timed-access register port
//
// Functional notes
// [RULE1] expiry with interrupt disabled sets the flag, no request.
// [RULE2] expiry with interrupt enabled sets the flag and raises a request.
// [RULE3] reset enabled: chip reset 512 clocks after expiry unless restarted.
// [RULE4] software sets restart only through the unlock sequence.
// [RULE5] interval select 00/01/10/11 gives 2^17, 2^20, 2^23, 2^26 clocks.
// [RULE6] counter advances on every device clock, no prescaler.
// [RULE7] interval select is clock_control bits 7:6; register resets to 0x03.
// [RULE8] flag at interval; reset follows 512 clocks later if enabled and not restarted.
// [RULE9] control write counts only right after 0xAA then 0x55 to key.
// [RULE10] restart bit clears the count so it starts from zero.
// [RULE11] a watchdog reset does not disable it; counting restarts.
// [RULE12] any other register write between or after keys cancels unlock.
module wdt_top #(
  parameter logic [26:0] INTERVAL_00 = wdt_pkg::WDT_INTERVAL_00,
  parameter logic [26:0] INTERVAL_01 = wdt_pkg::WDT_INTERVAL_01,
  parameter logic [26:0] INTERVAL_10 = wdt_pkg::WDT_INTERVAL_10,
  parameter logic [26:0] INTERVAL_11 = wdt_pkg::WDT_INTERVAL_11
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // special function register port
  input wire wdt_pkg::wdt_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // interrupt controller side
  input wire logic wdt_irq_enable,
  output logic wdt_irq_req,
  // system side
  output logic wdt_chip_reset,
  output logic [2:0] clk_mode
);
  function automatic logic [26:0] interval_limit(input logic [1:0] sel);
    logic [26:0] lim;
    lim = INTERVAL_00;
    if (sel == 2'b01) lim = INTERVAL_01;
    else if (sel == 2'b10) lim = INTERVAL_10;
    else if (sel == 2'b11) lim = INTERVAL_11;
    return lim;
  endfunction

  logic [7:0] clock_control_reg;
  logic [7:0] clock_control_next;
  logic wdt_reset_enable_reg;
  logic wdt_reset_enable_next;
  logic wdt_reset_flag_reg;
  logic wdt_reset_flag_next;
  logic wdt_irq_flag_reg;
  logic wdt_irq_flag_next;
  wdt_pkg::wdt_lock_t lock_reg;
  wdt_pkg::wdt_lock_t lock_next;
  logic [7:0] rdata_next;
  logic expire_w;
  logic grace_done_w;

  // address decode
  wire logic sel_clock_control_w = (sfr_req.addr == wdt_pkg::CLOCK_CONTROL_ADDR);
  wire logic sel_key_w = (sfr_req.addr == wdt_pkg::TIMED_ACCESS_KEY_ADDR);
  wire logic sel_watchdog_control_w = (sfr_req.addr == wdt_pkg::WATCHDOG_CONTROL_ADDR);
  wire logic wr_clock_control_w = sfr_req.we && sel_clock_control_w;
  wire logic wr_key_w = sfr_req.we && sel_key_w;
  wire logic wr_other_w = sfr_req.we && !sel_key_w;
  wire logic wr_ctl_ok_w = sfr_req.we && sel_watchdog_control_w &&
      (lock_reg == wdt_pkg::WDT_LOCK_OPEN); // [RULE9]
  wire logic [7:0] wd = sfr_req.wdata;
  wire logic key_first_w = wr_key_w && (wd == wdt_pkg::UNLOCK_KEY_FIRST);
  wire logic key_second_w = wr_key_w && (wd == wdt_pkg::UNLOCK_KEY_SECOND);

  // reset request and restart sources
  wire logic fire_w = grace_done_w && wdt_reset_enable_reg; // [RULE3]
  // software restart reaches the counter only via an unlocked write
  wire logic sw_restart_w = wr_ctl_ok_w && wd[wdt_pkg::WDT_RESTART_BIT]; // [RULE4]
  // the chip reset restarts the count instead of disabling the unit
  wire logic restart_w = sw_restart_w || fire_w; // [RULE11]
  wire logic [1:0] interval_sel_w =
      clock_control_reg[wdt_pkg::WDT_INTERVAL_SEL_HI:
                        wdt_pkg::WDT_INTERVAL_SEL_LO];
  wire logic [26:0] limit_w = interval_limit(interval_sel_w); // [RULE5]

  wdt_counter u_counter (
    .clock(clock), // [RULE6]
    .nrst(nrst),
    .restart(restart_w), // [RULE10]
    .limit(limit_w),
    .expire_pulse(expire_w),
    .grace_done_pulse(grace_done_w)
  );

  // unlock sequencer
  always_comb begin
    lock_next = lock_reg;
    if (key_first_w) begin
      lock_next = wdt_pkg::WDT_LOCK_FIRST; // [RULE9]
    end else if (key_second_w && (lock_reg == wdt_pkg::WDT_LOCK_FIRST)) begin
      lock_next = wdt_pkg::WDT_LOCK_OPEN; // [RULE9]
    end else if (wr_key_w || wr_other_w) begin
      // one protected write per sequence; stray writes cancel too
      lock_next = wdt_pkg::WDT_LOCK_IDLE; // [RULE12]
    end
  end

  // register updates; hardware set wins over a software clear
  always_comb begin
    clock_control_next = clock_control_reg;
    if (wr_clock_control_w) begin
      clock_control_next = {wd[7:6], 3'b000, wd[2:0]}; // [RULE7]
    end
    wdt_reset_enable_next = wr_ctl_ok_w ?
        wd[wdt_pkg::WDT_RESET_ENABLE_BIT] : wdt_reset_enable_reg; // [RULE9]
    wdt_irq_flag_next = expire_w || (wr_ctl_ok_w ?
        wd[wdt_pkg::WDT_IRQ_FLAG_BIT] : wdt_irq_flag_reg); // [RULE1]
    // software writing one here does not cause a chip reset
    wdt_reset_flag_next = fire_w || (wr_ctl_ok_w ?
        wd[wdt_pkg::WDT_RESET_FLAG_BIT] : wdt_reset_flag_reg);
  end

  // read data; restart reads as zero, unmapped reads as zero
  always_comb begin
    rdata_next = 8'h00;
    if (sel_clock_control_w) begin
      rdata_next = clock_control_reg;
    end else if (sel_watchdog_control_w) begin
      rdata_next = {4'h0, wdt_irq_flag_reg, wdt_reset_flag_reg,
                    wdt_reset_enable_reg, 1'b0};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clock_control_reg <= wdt_pkg::CLOCK_CONTROL_RESET; // [RULE7]
      wdt_reset_enable_reg <= wdt_pkg::WATCHDOG_CONTROL_RESET[1];
      wdt_reset_flag_reg <= wdt_pkg::WATCHDOG_CONTROL_RESET[2];
      wdt_irq_flag_reg <= wdt_pkg::WATCHDOG_CONTROL_RESET[3];
      lock_reg <= wdt_pkg::WDT_LOCK_IDLE;
    end else begin
      clock_control_reg <= clock_control_next;
      wdt_reset_enable_reg <= wdt_reset_enable_next;
      wdt_reset_flag_reg <= wdt_reset_flag_next;
      wdt_irq_flag_reg <= wdt_irq_flag_next;
      lock_reg <= lock_next;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
      wdt_irq_req <= 1'b0;
      wdt_chip_reset <= 1'b0;
      clk_mode <= wdt_pkg::CLOCK_CONTROL_RESET[2:0];
    end else begin
      if (sfr_req.re) begin
        sfr_rdata <= rdata_next;
      end
      wdt_irq_req <= wdt_irq_flag_next && wdt_irq_enable; // [RULE2]
      wdt_chip_reset <= fire_w; // [RULE3]
      clk_mode <= clock_control_next[wdt_pkg::CLK_MODE_HI:
                                     wdt_pkg::CLK_MODE_LO];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_key_first;
    sfr_req.we && sel_key_w && (sfr_req.wdata == wdt_pkg::UNLOCK_KEY_FIRST);
  endsequence
  sequence s_key_second;
    sfr_req.we && sel_key_w && (sfr_req.wdata == wdt_pkg::UNLOCK_KEY_SECOND);
  endsequence
  sequence s_set_reset_enable;
    sfr_req.we && sel_watchdog_control_w && sfr_req.wdata[1];
  endsequence

  AST_FLAG_ON_EXPIRE: assert property ( // [RULE1]
    expire_w |=> wdt_irq_flag_reg)
    else $error("expiry did not set the interrupt flag");
  AST_NO_REQ_WHEN_MASKED: assert property ( // [RULE1]
    !wdt_irq_enable |=> !wdt_irq_req)
    else $error("request raised with interrupt disabled");
  AST_REQ_WHEN_ENABLED: assert property ( // [RULE2]
    expire_w && wdt_irq_enable |=> wdt_irq_req && wdt_irq_flag_reg)
    else $error("no request after enabled expiry");
  AST_RESET_WHEN_ENABLED: assert property ( // [RULE3]
    grace_done_w && wdt_reset_enable_reg |=> wdt_chip_reset ##1 !wdt_chip_reset)
    else $error("chip reset not a single pulse after grace");
  AST_NO_RESET_DISABLED: assert property ( // [RULE3]
    !wdt_reset_enable_reg |=> !wdt_chip_reset)
    else $error("chip reset while disabled");
  AST_INTERVAL_SELECT: assert property ( // [RULE5]
    interval_sel_w == 2'b11 |-> limit_w == INTERVAL_11)
    else $error("wrong interval for select 11");
  AST_CLOCK_CONTROL_WRITE: assert property ( // [RULE7]
    wr_clock_control_w |=> interval_sel_w == $past(sfr_req.wdata[7:6]))
    else $error("interval select not written");
  AST_UNLOCKED_WRITE: assert property ( // [RULE9]
    s_key_first ##1 s_key_second ##1 s_set_reset_enable |=> wdt_reset_enable_reg)
    else $error("unlocked control write did not take effect");
  AST_LOCKED_WRITE: assert property ( // [RULE9]
    sfr_req.we && sel_watchdog_control_w && (lock_reg != wdt_pkg::WDT_LOCK_OPEN)
    |=> $stable(wdt_reset_enable_reg))
    else $error("locked control write took effect");
  AST_RESTART_ON_RESET: assert property ( // [RULE11]
    wdt_chip_reset |-> $past(restart_w) && wdt_reset_flag_reg)
    else $error("chip reset without restart and flag");
  AST_UNLOCK_CANCEL: assert property ( // [RULE12]
    sfr_req.we && !sel_key_w |=> lock_reg == wdt_pkg::WDT_LOCK_IDLE)
    else $error("unlock survived a foreign write");
endmodule // wdt_top

//--- tb/test_watchdog_timeout_reset_unit.sv
// self-checking bench of the watchdog timeout and reset unit
module test_watchdog_timeout_reset_unit;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    $display("wrong value %s exp %0h got %0h", nm, exp, got); fails++; end end
  // short intervals keep the run small; grace stays 512
  localparam logic [26:0] IV [4] = '{27'h40, 27'h80, 27'h100, 27'h200};
  logic clock;
  logic nrst;
  logic wdt_irq_enable;
  logic wdt_irq_req;
  logic wdt_chip_reset;
  logic [7:0] sfr_rdata;
  logic [2:0] clk_mode;
  logic [7:0] v;
  wdt_pkg::wdt_sfr_req_t sfr_req;
  int fails;
  int num_checks;
  int n;
  int hits;

  wdt_top #(.INTERVAL_00(IV[0]), .INTERVAL_01(IV[1]), .INTERVAL_10(IV[2]),
    .INTERVAL_11(IV[3])) DUT (.clock(clock), .nrst(nrst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .wdt_irq_enable(wdt_irq_enable),
    .wdt_irq_req(wdt_irq_req), .wdt_chip_reset(wdt_chip_reset),
    .clk_mode(clk_mode));

  always #2 clock = ~clock;

  task automatic close_out();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one write or read; read data lands on the edge after the strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{we: w, re: !w, addr: a, wdata: d};
    @(posedge clock);
    sfr_req <= '0;
    #1 v = sfr_rdata;
  endtask

  // keys and control byte back to back, so the unlock check sees them
  task automatic ctl(input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{we: 1'b1, re: 1'b0, addr: 8'hC7, wdata: 8'hAA};
    @(posedge clock);
    sfr_req <= '{we: 1'b1, re: 1'b0, addr: 8'hC7, wdata: 8'h55};
    @(posedge clock);
    sfr_req <= '{we: 1'b1, re: 1'b0, addr: 8'hD8, wdata: d};
    @(posedge clock);
    sfr_req <= '0;
  endtask

  task automatic wait_hi(input bit rst, input int lim, output int cnt);
    cnt = 0;
    #1;
    while ((rst ? wdt_chip_reset : wdt_irq_req) !== 1'b1) begin
      @(posedge clock);
      #1;
      cnt++;
      if (cnt > lim) begin
        $display("wrong value wait exp 1 got 0");
        fails++;
        close_out();
      end
    end
  endtask

  // chip reset is a one-cycle pulse, so look every cycle
  task automatic quiet(input int cyc, output int h);
    h = 0;
    repeat (cyc) begin
      @(posedge clock);
      #1;
      if (wdt_irq_req !== 1'b0 || wdt_chip_reset !== 1'b0) h++;
    end
  endtask

  task automatic t_reset_vals();
    `CHK("clk_mode", 3'b011, clk_mode)
    bus(1'b0, 8'h8E, 8'h00);
    `CHK("clock_control", 8'h03, v)
    bus(1'b0, 8'hD8, 8'h00);
    `CHK("watchdog_control", 8'h00, v)
    bus(1'b0, 8'hC7, 8'h00);
    `CHK("key read", 8'h00, v)
    bus(1'b0, 8'h42, 8'h00);
    `CHK("unmapped read", 8'h00, v)
  endtask

  // any leak leaves reset enable set, so one check covers all cases
  task automatic t_lock();
    bus(1'b1, 8'hD8, 8'h02);
    bus(1'b1, 8'hC7, 8'hAA);
    bus(1'b1, 8'h8E, 8'h03);
    bus(1'b1, 8'hC7, 8'h55);
    bus(1'b1, 8'hD8, 8'h02);
    bus(1'b1, 8'hC7, 8'hAA);
    bus(1'b1, 8'hC7, 8'h55);
    bus(1'b1, 8'h42, 8'h00);
    bus(1'b1, 8'hD8, 8'h02);
    bus(1'b1, 8'hC7, 8'hAA);
    bus(1'b1, 8'hC7, 8'h56);
    bus(1'b1, 8'hD8, 8'h02);
    bus(1'b0, 8'hD8, 8'h00);
    `CHK("locked control", 3'b000, v[2:0])
    ctl(8'h02);
    bus(1'b0, 8'hD8, 8'h00);
    `CHK("unlocked control", 3'b010, v[2:0])
    bus(1'b1, 8'hD8, 8'h00);
    bus(1'b0, 8'hD8, 8'h00);
    `CHK("second control", 3'b010, v[2:0])
    ctl(8'h00);
  endtask

  task automatic t_intervals();
    @(posedge clock);
    wdt_irq_enable <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h8E, {s[1:0], 4'hF, s[1:0]});
      bus(1'b0, 8'h8E, 8'h00);
      `CHK("clock_control", {s[1:0], 4'h1, s[1:0]}, v)
      `CHK("clk_mode", {1'b1, s[1:0]}, clk_mode)
      ctl(8'h01);
      wait_hi(1'b0, 600, n);
      `CHK("interval", 1'b1, n >= IV[s] - 2 && n <= IV[s] + 4)
      bus(1'b0, 8'hD8, 8'h00);
      `CHK("irq flag", 8'h08, v)
      ctl(8'h01);
      #9;
      `CHK("irq req", 1'b0, wdt_irq_req)
    end
  endtask

  task automatic t_no_irq();
    @(posedge clock);
    wdt_irq_enable <= 1'b0;
    bus(1'b1, 8'h8E, 8'h03);
    ctl(8'h01);
    quiet(80, hits);
    `CHK("irq while disabled", 0, hits)
    bus(1'b0, 8'hD8, 8'h00);
    `CHK("irq flag", 8'h08, v)
  endtask

  task automatic t_restart_and_fire();
    ctl(8'h03);
    @(posedge clock);
    wdt_irq_enable <= 1'b1;
    hits = 0;
    repeat (8) begin
      quiet(40, n);
      hits += n;
      ctl(8'h03);
    end
    `CHK("restarted events", 0, hits)
    wait_hi(1'b0, 80, n);
    wait_hi(1'b1, 600, n);
    `CHK("grace", 1'b1, n >= 509 && n <= 515)
    bus(1'b0, 8'hD8, 8'h00);
    `CHK("after fire", 8'h0E, v)
    ctl(8'h02);
    // let the cleared flag reach the request before waiting again
    #8;
    wait_hi(1'b0, 80, n);
    `CHK("refire", 1'b1, n >= 48 && n <= 60)
    // restart inside the grace must cancel the pending chip reset
    @(posedge clock);
    wdt_irq_enable <= 1'b0;
    ctl(8'h03);
    quiet(540, hits);
    `CHK("restart in grace", 0, hits)
  endtask

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    sfr_req = '0;
    wdt_irq_enable = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_reset_vals();
    t_lock();
    t_intervals();
    t_no_irq();
    t_restart_and_fire();
    close_out();
  end

  initial begin
    #200000;
    $display("wrong value run time exp done got hang");
    fails++;
    close_out();
  end
endmodule // test_watchdog_timeout_reset_unit
